//--- rtl/vwc_pkg.sv
package vwc_pkg;

  // Local I/O register offsets.
  localparam logic [15:0] OFS_STD_WINDOW_UPPER_ADDR = 16'h0141;
  localparam logic [15:0] OFS_EXT_ADDR_AND_MODIFIER = 16'h0142;
  localparam logic [15:0] OFS_IRQ_LEVEL_ENABLE = 16'h0147;
  localparam logic [15:0] OFS_SYSTEM_CONDITION_ENABLE = 16'h0148;
  localparam logic [15:0] OFS_CONDITION_CLEAR_HOLD = 16'h0149;
  localparam logic [15:0] OFS_ACK_DONE_VECTOR = 16'h014B;
  localparam logic [15:0] OFS_SYSTEM_CONDITION_STATUS = 16'h014C;

  // Condition bit positions shared by enable, clear-hold and status bytes.
  localparam int BIT_SYS_FAILURE = 7;
  localparam int BIT_SOFTWARE_NMI = 5;
  localparam int BIT_AC_FAILURE = 4;
  localparam int BIT_BUS_ERROR = 3;
  localparam int BIT_VME_IRQ = 2;
  localparam int BIT_ACK_DONE = 0;

  // Writable bit masks; all other bits are reserved and read as zero.
  localparam logic [7:0] MASK_IRQ_LEVEL_ENABLE = 8'h7F;
  localparam logic [7:0] MASK_SYSTEM_CONDITION_ENABLE = 8'h9D;
  localparam logic [7:0] MASK_CONDITION_CLEAR_HOLD = 8'h29;
  localparam logic [15:0] MASK_EXT_ADDR_AND_MODIFIER = 16'hFF3F;

  // Values after reset; the undefined registers come up as zero here.
  localparam logic [7:0] RST_STD_WINDOW_UPPER_ADDR = 8'h00;
  localparam logic [15:0] RST_EXT_ADDR_AND_MODIFIER = 16'h0000;
  localparam logic [7:0] RST_IRQ_LEVEL_ENABLE = 8'h00;
  localparam logic [7:0] RST_SYSTEM_CONDITION_ENABLE = 8'h00;
  localparam logic [7:0] RST_CONDITION_CLEAR_HOLD = 8'h00;
  localparam logic [7:0] RST_ACK_DONE_VECTOR = 8'h00;

  // Pin synchroniser depth.
  localparam int SYNC_STAGES = 3;

  // Address-modifier classes.
  typedef enum {
    AM_EXTENDED,
    AM_STANDARD,
    AM_SHORT,
    AM_USER
  } vwc_am_class_t;

endpackage : vwc_pkg

//--- rtl/vwc_window_ctrl.sv
// What this block does
// R1 - Bus access enable clear: no bus transfers, no bus-driven CPU interrupts.
// R2 - Failure line release bit always controls the failure line.
// R3 - Drive bus reset from front panel if controller; else obey bus reset.
// R4 - Write-only byte at 0x141 holds address bits A16-A23 for real window.
// R5 - Standard byte used only in real window with 24-bit or wider modifier.
// R6 - Short modifier accesses expose the whole short space without that byte.
// R7 - Protected window maps 24 address bits directly from CPU address.
// R8 - Word register at 0x142 holds A31-A24 and modifier; byte writes ignored.
// R9 - Stored modifier bits drive AM5-AM0 unchanged and select cycle class.
// R10 - Software loads a valid modifier code before using the bus.
// R11 - Extended byte drives A24-A31, selecting the protected window segment.
// R12 - Real window 32-bit accesses combine standard and extended bytes.
// R13 - Byte at 0x147 enables IRQ1-7 individually; cleared on reset.
// R14 - Highest pending enabled level acknowledged first, level 7 highest.
// R15 - Byte at 0x148 holds group enables; cleared on reset.
// R16 - Bus error latched on error cycle or timeout, forwarded if enabled.
// R17 - IRQ lines reach CPU only with group and individual enable set.
// R18 - Acknowledge-done raised on handler acknowledge, forwarded if enabled.
// R19 - Byte at 0x149: zero bit clears and holds off its latched condition.
// R20 - Polling software masks, polls, clears then re-arms the clear bit.
// R21 - Byte at 0x14B holds the acknowledge-done vector, no bus cycle.
// R22 - Reading 0x14C returns raw conditions even when group-masked; the IRQ bit counts only level-enabled IRQs.
// R23 - Any write to 0x14C raises the software NMI condition.
// R24 - NMI output is the OR of the enabled system failure, AC failure, bus error and acknowledge-done conditions plus software NMI.
// R25 - Reserved bits read zero and writes to them are ignored.
`timescale 1ns/1ps

module vwc_window_ctrl
  import vwc_pkg::*;
#(
  parameter int NUM_IRQ = 7
) (
  // Clock and reset
  input wire logic clk,
  input wire logic rst_b,
  // Local I/O port from the CPU
  input wire logic [15:0] ioAddr,
  input wire logic ioWrStb,
  input wire logic ioRdStb,
  input wire logic ioWordAccess,
  input wire logic [15:0] ioWrData,
  output logic [7:0] ioRdData_q,
  output logic ioRdValid_q,
  // Global controls from the access control logic
  input wire logic busAccessEnable,
  input wire logic failureLineRelease,
  // Window access requests from the CPU
  input wire logic winReq,
  input wire logic winProtected,
  input wire logic [23:0] cpuAddr,
  output logic vmeCycleStart_q,
  output logic winRefused_q,
  output logic [31:0] vmeAddr_q,
  output logic [5:0] vmeAm_q,
  // Bus-side events from the same clock domain
  input wire logic berrCycle,
  input wire logic busTimeout,
  input wire logic ackDone,
  output logic [7:0] ackDoneVector_q,
  // Bus pins and board straps
  input wire logic [NUM_IRQ:1] irqIn_b,
  input wire logic sysFailIn_b,
  input wire logic acFailIn_b,
  input wire logic sysResetIn_b,
  input wire logic frontPanelReset_b,
  input wire logic sysController,
  output logic sysFailOut_q,
  output logic sysFailOe_b_q,
  output logic sysResetOut_q,
  output logic sysResetOe_b_q,
  output logic localResetReq_q,
  // CPU interrupt outputs
  output logic cpuNmi_q,
  output logic irqAckReq_q,
  output logic [2:0] irqAckLevel_q
);

  localparam int NSYNC = NUM_IRQ + 5;
  // Reset shows every pin at its idle level, so no phantom bus reset or IRQ follows reset.
  localparam logic [NSYNC-1:0] PIN_IDLE = {{NUM_IRQ{1'b1}}, 4'hF, 1'b0};

  generate
    if (NUM_IRQ != 7) begin : g_bad_irq
      $error("vwc_window_ctrl supports exactly seven interrupt levels");
    end
  endgenerate

  function automatic logic regHit(input logic [15:0] addr, input logic [15:0] ofs);
    regHit = (addr == ofs);
  endfunction : regHit

  function automatic vwc_am_class_t amClass(input logic [5:0] am);
    if (am[5:4] == 2'b00) begin
      amClass = AM_EXTENDED;
    end else if (am[5:4] == 2'b11) begin
      amClass = AM_STANDARD;
    end else if (am[5:3] == 3'b101) begin
      amClass = AM_SHORT;
    end else begin
      amClass = AM_USER;
    end
  endfunction : amClass

  function automatic logic [2:0] highestLevel(input logic [NUM_IRQ:1] pend);
    logic [2:0] lvl;
    lvl = 3'h0;
    for (int i = 1; i <= NUM_IRQ; i++) begin
      if (pend[i]) begin
        lvl = 3'(i);
      end
    end
    highestLevel = lvl;
  endfunction : highestLevel

  // Register storage.
  logic [7:0] stdWindowUpperAddr_q;
  logic [15:0] extAddrAndModifier_q;
  logic [7:0] irqLevelEnable_q;
  logic [7:0] systemConditionEnable_q;
  logic [7:0] conditionClearHold_q;

  // Pin synchroniser: stage one feeds stage two only.
  logic [NSYNC-1:0] pinRaw;
  logic [NSYNC-1:0] syncS1_q;
  logic [NSYNC-1:0] syncS2_q;
  logic [NSYNC-1:0] syncS3_q;
  logic [NSYNC-1:0] pinStable_q;

  assign pinRaw = {irqIn_b, sysFailIn_b, acFailIn_b, sysResetIn_b,
                   frontPanelReset_b, sysController};

  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      syncS1_q <= PIN_IDLE;
      syncS2_q <= PIN_IDLE;
      syncS3_q <= PIN_IDLE;
    end else begin
      syncS1_q <= pinRaw;
      syncS2_q <= syncS1_q;
      syncS3_q <= syncS2_q;
    end
  end

  // A pin change counts once the second and third stages agree.
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      pinStable_q <= PIN_IDLE;
    end else begin
      for (int i = 0; i < NSYNC; i++) begin
        if (syncS2_q[i] == syncS3_q[i]) begin
          pinStable_q[i] <= syncS3_q[i];
        end
      end
    end
  end

  logic [NUM_IRQ:1] irqActive;
  logic sysFailActive;
  logic acFailActive;
  logic sysResetActive;
  logic frontPanelActive;
  logic isController;

  assign irqActive = ~pinStable_q[NSYNC-1 -: NUM_IRQ];
  assign sysFailActive = ~pinStable_q[4];
  assign acFailActive = ~pinStable_q[3];
  assign sysResetActive = ~pinStable_q[2];
  assign frontPanelActive = ~pinStable_q[1];
  assign isController = pinStable_q[0];

  logic wrStd;
  logic wrExt;
  logic wrIrqEn;
  logic wrGrpEn;
  logic wrClr;
  logic wrVec;
  logic wrSoft;

  assign wrStd = ioWrStb && regHit(ioAddr, OFS_STD_WINDOW_UPPER_ADDR);
  // R8 word-only write
  assign wrExt = ioWrStb && ioWordAccess && regHit(ioAddr, OFS_EXT_ADDR_AND_MODIFIER);
  assign wrIrqEn = ioWrStb && regHit(ioAddr, OFS_IRQ_LEVEL_ENABLE);
  assign wrGrpEn = ioWrStb && regHit(ioAddr, OFS_SYSTEM_CONDITION_ENABLE);
  assign wrClr = ioWrStb && regHit(ioAddr, OFS_CONDITION_CLEAR_HOLD);
  assign wrVec = ioWrStb && regHit(ioAddr, OFS_ACK_DONE_VECTOR);
  assign wrSoft = ioWrStb && regHit(ioAddr, OFS_SYSTEM_CONDITION_STATUS);

  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      stdWindowUpperAddr_q <= RST_STD_WINDOW_UPPER_ADDR;
      extAddrAndModifier_q <= RST_EXT_ADDR_AND_MODIFIER;
      ackDoneVector_q <= RST_ACK_DONE_VECTOR;
    end else begin
      // R4 standard address byte
      if (wrStd) begin
        stdWindowUpperAddr_q <= ioWrData[7:0];
      end
      // R8 extended and modifier
      if (wrExt) begin
        extAddrAndModifier_q <= ioWrData & MASK_EXT_ADDR_AND_MODIFIER;
      end
      // R21 local vector store
      if (wrVec) begin
        ackDoneVector_q <= ioWrData[7:0];
      end
    end
  end

  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      irqLevelEnable_q <= RST_IRQ_LEVEL_ENABLE;
      systemConditionEnable_q <= RST_SYSTEM_CONDITION_ENABLE;
      conditionClearHold_q <= RST_CONDITION_CLEAR_HOLD;
    end else begin
      // R13 level enables
      if (wrIrqEn) begin
        irqLevelEnable_q <= ioWrData[7:0] & MASK_IRQ_LEVEL_ENABLE;
      end
      // R15 group enables
      if (wrGrpEn) begin
        systemConditionEnable_q <= ioWrData[7:0] & MASK_SYSTEM_CONDITION_ENABLE;
      end
      // R19 clear-hold bits
      if (wrClr) begin
        conditionClearHold_q <= ioWrData[7:0] & MASK_CONDITION_CLEAR_HOLD;
      end
    end
  end

  // Latched conditions. A zero hold bit beats a simultaneous event.
  logic softNmiLat_q;
  logic busErrorLat_q;
  logic ackDoneLat_q;

  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      softNmiLat_q <= 1'b0;
      busErrorLat_q <= 1'b0;
      ackDoneLat_q <= 1'b0;
    end else begin
      // R19 hold off cleared
      if (!conditionClearHold_q[BIT_SOFTWARE_NMI]) begin
        softNmiLat_q <= 1'b0;
      end else if (wrSoft) begin
        // R23 any write raises
        softNmiLat_q <= 1'b1;
      end
      if (!conditionClearHold_q[BIT_BUS_ERROR]) begin
        busErrorLat_q <= 1'b0;
      end else if (busAccessEnable && (berrCycle || busTimeout)) begin
        // R16 error or timeout
        busErrorLat_q <= 1'b1;
      end
      if (!conditionClearHold_q[BIT_ACK_DONE]) begin
        ackDoneLat_q <= 1'b0;
      end else if (busAccessEnable && ackDone) begin
        // R18 acknowledge done
        ackDoneLat_q <= 1'b1;
      end
    end
  end

  // R17 both enables gate
  logic [NUM_IRQ:1] irqPending;
  logic [NUM_IRQ:1] irqLevelMask;
  assign irqLevelMask = irqLevelEnable_q[NUM_IRQ-1:0];
  assign irqPending = irqActive & irqLevelMask
                      & {NUM_IRQ{busAccessEnable && systemConditionEnable_q[BIT_VME_IRQ]}};

  // R22 raw condition byte
  logic [7:0] rawStatus;
  always_comb begin
    rawStatus = 8'h00;
    rawStatus[BIT_SYS_FAILURE] = sysFailActive;
    rawStatus[BIT_SOFTWARE_NMI] = softNmiLat_q;
    rawStatus[BIT_AC_FAILURE] = acFailActive;
    rawStatus[BIT_BUS_ERROR] = busErrorLat_q;
    rawStatus[BIT_VME_IRQ] = |(irqActive & irqLevelMask);
    rawStatus[BIT_ACK_DONE] = ackDoneLat_q;
  end

  // R25 reserved read zero
  logic [7:0] rdMux;
  always_comb begin
    rdMux = 8'h00;
    if (regHit(ioAddr, OFS_IRQ_LEVEL_ENABLE)) begin
      rdMux = irqLevelEnable_q;
    end else if (regHit(ioAddr, OFS_SYSTEM_CONDITION_ENABLE)) begin
      rdMux = systemConditionEnable_q;
    end else if (regHit(ioAddr, OFS_CONDITION_CLEAR_HOLD)) begin
      rdMux = conditionClearHold_q;
    end else if (regHit(ioAddr, OFS_ACK_DONE_VECTOR)) begin
      rdMux = ackDoneVector_q;
    end else if (regHit(ioAddr, OFS_SYSTEM_CONDITION_STATUS)) begin
      rdMux = rawStatus;
    end
  end

  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      ioRdData_q <= 8'h00;
      ioRdValid_q <= 1'b0;
    end else begin
      ioRdValid_q <= ioRdStb;
      if (ioRdStb) begin
        ioRdData_q <= rdMux;
      end
    end
  end

  // Window address formation.
  logic [7:0] extUpper;
  logic [5:0] amCode;
  logic [31:0] addrNext;
  assign extUpper = extAddrAndModifier_q[15:8];
  assign amCode = extAddrAndModifier_q[5:0];

  always_comb begin
    addrNext = {extUpper, 8'h00, cpuAddr[15:0]};
    if (winProtected) begin
      // R7 direct 24 bits, R11 segment select
      addrNext = {extUpper, cpuAddr};
    end else begin
      case (amClass(amCode))
        // R12 combined upper bits
        AM_EXTENDED: addrNext = {extUpper, stdWindowUpperAddr_q, cpuAddr[15:0]};
        // R5 standard byte applied
        AM_STANDARD: addrNext = {extUpper, stdWindowUpperAddr_q, cpuAddr[15:0]};
        // R6 whole short space
        AM_SHORT: addrNext = {extUpper, 8'h00, cpuAddr[15:0]};
        AM_USER: addrNext = {extUpper, 8'h00, cpuAddr[15:0]};
        default: addrNext = {extUpper, 8'h00, cpuAddr[15:0]};
      endcase
    end
  end

  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      vmeCycleStart_q <= 1'b0;
      winRefused_q <= 1'b0;
      vmeAddr_q <= 32'h0000_0000;
      vmeAm_q <= 6'h00;
    end else begin
      // R1 no transfers when disabled
      vmeCycleStart_q <= winReq && busAccessEnable;
      winRefused_q <= winReq && !busAccessEnable;
      if (winReq && busAccessEnable) begin
        vmeAddr_q <= addrNext;
        // R9 modifier unchanged
        vmeAm_q <= amCode;
      end
    end
  end

  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      sysFailOut_q <= 1'b0;
      sysFailOe_b_q <= 1'b0;
      sysResetOut_q <= 1'b0;
      sysResetOe_b_q <= 1'b1;
      localResetReq_q <= 1'b0;
    end else begin
      // R2 failure line control
      sysFailOut_q <= 1'b0;
      sysFailOe_b_q <= failureLineRelease;
      // R3 reset drive or obey
      sysResetOut_q <= 1'b0;
      sysResetOe_b_q <= !(isController && frontPanelActive);
      localResetReq_q <= !isController && sysResetActive;
    end
  end

  // R24 combined NMI
  logic nmiNext;
  assign nmiNext =
      (systemConditionEnable_q[BIT_SYS_FAILURE] && busAccessEnable && sysFailActive)
      || (systemConditionEnable_q[BIT_AC_FAILURE] && busAccessEnable && acFailActive)
      || (systemConditionEnable_q[BIT_BUS_ERROR] && busErrorLat_q)
      || (systemConditionEnable_q[BIT_ACK_DONE] && ackDoneLat_q)
      || softNmiLat_q;

  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      cpuNmi_q <= 1'b0;
      irqAckReq_q <= 1'b0;
      irqAckLevel_q <= 3'h0;
    end else begin
      cpuNmi_q <= nmiNext;
      irqAckReq_q <= |irqPending;
      // R14 highest level first
      irqAckLevel_q <= highestLevel(irqPending);
    end
  end

endmodule : vwc_window_ctrl

//--- tb/vwc_chk.sv
`timescale 1ns/1ps
module vwc_chk
  import vwc_pkg::*;
(
  // Clock and reset
  input wire logic clk,
  input wire logic rst_b,
  // Register and window ports
  input wire logic [15:0] ioAddr,
  input wire logic ioRdStb,
  input wire logic [7:0] ioRdData_q,
  input wire logic busAccessEnable,
  input wire logic failureLineRelease,
  input wire logic winReq,
  input wire logic winProtected,
  input wire logic [23:0] cpuAddr,
  input wire logic vmeCycleStart_q,
  input wire logic winRefused_q,
  input wire logic [31:0] vmeAddr_q,
  input wire logic [5:0] vmeAm_q,
  // Pins and interrupt outputs
  input wire logic frontPanelReset_b,
  input wire logic sysController,
  input wire logic sysFailOe_b_q,
  input wire logic sysResetOe_b_q,
  input wire logic cpuNmi_q,
  input wire logic irqAckReq_q
);
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (!rst_b);

  AST_REFUSE: assert property (winReq && !busAccessEnable |=> winRefused_q && !vmeCycleStart_q)
    else $error("request not refused");
  AST_ADDR_HOLD: assert property (!vmeCycleStart_q |-> $stable(vmeAddr_q) && $stable(vmeAm_q))
    else $error("address moved without cycle");
  AST_PROT_MAP: assert property (vmeCycleStart_q && $past(winProtected) |-> vmeAddr_q[23:0] == $past(cpuAddr))
    else $error("protected address wrong");
  AST_SHORT: assert property (vmeCycleStart_q && !$past(winProtected) && vmeAm_q[5:3] == 3'h5 |-> vmeAddr_q[23:16] == 8'h00)
    else $error("short access used upper byte");
  AST_FAIL_LINE: assert property ($stable(failureLineRelease)[*3] |-> sysFailOe_b_q == failureLineRelease)
    else $error("failure line not following bit");
  AST_NO_IRQ: assert property (!busAccessEnable[*2] |-> !irqAckReq_q)
    else $error("interrupt while bus access off");
  AST_CTRL_RST: assert property ((sysController && !frontPanelReset_b)[*8] |-> !sysResetOe_b_q)
    else $error("bus reset not driven");
  AST_WO_READ: assert property (ioRdStb && ioAddr == OFS_STD_WINDOW_UPPER_ADDR |=> ioRdData_q == 8'h00)
    else $error("write-only register read back");

  cover property (vmeCycleStart_q);
  cover property (winRefused_q);
  cover property ($rose(cpuNmi_q));
endmodule : vwc_chk

bind vwc_window_ctrl vwc_chk u_chk (.clk, .rst_b, .ioAddr, .ioRdStb, .ioRdData_q,
  .busAccessEnable, .failureLineRelease, .winReq, .winProtected, .cpuAddr, .vmeCycleStart_q,
  .winRefused_q, .vmeAddr_q, .vmeAm_q, .frontPanelReset_b, .sysController, .sysFailOe_b_q,
  .sysResetOe_b_q, .cpuNmi_q, .irqAckReq_q);

//--- tb/vwc_bus_far.sv
`timescale 1ns/1ps
module vwc_bus_far (
  // Far-side pull requests, high pulls the line low
  input wire logic [7:1] irqPull,
  input wire logic failPull,
  input wire logic rstPull,
  input wire logic sysFailOe_b_q,
  input wire logic sysResetOe_b_q,
  // Resolved lines, pulled up when nobody drives
  output logic [7:1] irqIn_b,
  output logic sysFailIn_b,
  output logic sysResetIn_b
);
  assign irqIn_b = ~irqPull;
  assign sysFailIn_b = !(failPull || !sysFailOe_b_q);
  assign sysResetIn_b = !(rstPull || !sysResetOe_b_q);
endmodule : vwc_bus_far

//--- tb/vwc_window_ctrl_tb.sv
`timescale 1ns/1ps
module vwc_window_ctrl_tb
  import vwc_pkg::*;
;
  logic clk, rst_b, ioWrStb, ioRdStb, ioWordAccess, ioRdValid_q, winReq, winProtected;
  logic [15:0] ioAddr, ioWrData;
  logic [7:0] ioRdData_q, ackDoneVector_q;
  logic busAccessEnable, failureLineRelease, vmeCycleStart_q, winRefused_q;
  logic [23:0] cpuAddr;
  logic [31:0] vmeAddr_q;
  logic [5:0] vmeAm_q;
  logic berrCycle, busTimeout, ackDone, frontPanelReset_b, sysController, acFailIn_b;
  logic [7:1] irqIn_b, irqPull;
  logic sysFailIn_b, sysResetIn_b, failPull, rstPull, sysFailOut_q, sysFailOe_b_q;
  logic sysResetOut_q, sysResetOe_b_q, localResetReq_q, cpuNmi_q, irqAckReq_q;
  logic [2:0] irqAckLevel_q;
  int failCount = 0;
  int compares = 0;

  vwc_window_ctrl #(.NUM_IRQ(7)) u_dut (.clk, .rst_b, .ioAddr, .ioWrStb, .ioRdStb,
    .ioWordAccess, .ioWrData, .ioRdData_q, .ioRdValid_q, .busAccessEnable,
    .failureLineRelease, .winReq, .winProtected, .cpuAddr, .vmeCycleStart_q, .winRefused_q,
    .vmeAddr_q, .vmeAm_q, .berrCycle, .busTimeout, .ackDone, .ackDoneVector_q, .irqIn_b,
    .sysFailIn_b, .acFailIn_b, .sysResetIn_b, .frontPanelReset_b, .sysController,
    .sysFailOut_q, .sysFailOe_b_q, .sysResetOut_q, .sysResetOe_b_q, .localResetReq_q,
    .cpuNmi_q, .irqAckReq_q, .irqAckLevel_q);
  vwc_bus_far u_far (.irqPull, .failPull, .rstPull, .sysFailOe_b_q, .sysResetOe_b_q,
    .irqIn_b, .sysFailIn_b, .sysResetIn_b);

  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end

  task automatic chk(input string n, input logic [31:0] e, input logic [31:0] g);
    compares++;
    if (g !== e) begin
      failCount++;
      $display("mismatch %s expected %h seen %h", n, e, g);
    end
  endtask : chk

  task automatic tick(input int n);
    repeat (n) @(negedge clk);
  endtask : tick

  task automatic wr(input logic [15:0] a, input logic [15:0] d, input logic w);
    @(negedge clk);
    ioAddr = a;
    ioWrData = d;
    ioWordAccess = w;
    ioWrStb = 1'b1;
    @(negedge clk);
    ioWrStb = 1'b0;
  endtask : wr

  task automatic rd(input logic [15:0] a, input logic [7:0] e);
    @(negedge clk);
    ioAddr = a;
    ioRdStb = 1'b1;
    @(negedge clk);
    ioRdStb = 1'b0;
    chk("ioRdValid_q", 32'h1, ioRdValid_q);
    chk("ioRdData_q", e, ioRdData_q);
  endtask : rd

  task automatic win(input logic p, input logic [23:0] a, input logic [31:0] e);
    @(negedge clk);
    winProtected = p;
    cpuAddr = a;
    winReq = 1'b1;
    @(negedge clk);
    winReq = 1'b0;
    chk("vmeCycleStart_q", busAccessEnable, vmeCycleStart_q);
    chk("winRefused_q", !busAccessEnable, winRefused_q);
    chk("vmeAddr_q", e, vmeAddr_q);
  endtask : win

  // Pulses one event for a single cycle, then waits for the interrupt to settle.
  task automatic pulse(ref logic s, input logic nmi);
    @(negedge clk);
    s = 1'b1;
    @(negedge clk);
    s = 1'b0;
    tick(1);
    chk("cpuNmi_q", nmi, cpuNmi_q);
  endtask : pulse

  task automatic t_regs;
    rd(OFS_IRQ_LEVEL_ENABLE, 8'h00);
    rd(OFS_SYSTEM_CONDITION_ENABLE, 8'h00);
    rd(OFS_CONDITION_CLEAR_HOLD, 8'h00);
    wr(OFS_IRQ_LEVEL_ENABLE, 16'h00FF, 1'b0);
    rd(OFS_IRQ_LEVEL_ENABLE, 8'h7F);
    wr(OFS_SYSTEM_CONDITION_ENABLE, 16'h00FF, 1'b0);
    rd(OFS_SYSTEM_CONDITION_ENABLE, 8'h9D);
    wr(OFS_CONDITION_CLEAR_HOLD, 16'h00FF, 1'b0);
    rd(OFS_CONDITION_CLEAR_HOLD, 8'h29);
    wr(OFS_ACK_DONE_VECTOR, 16'h00A5, 1'b0);
    rd(OFS_ACK_DONE_VECTOR, 8'hA5);
    chk("ackDoneVector_q", 32'hA5, ackDoneVector_q);
    rd(16'h0143, 8'h00);
    wr(OFS_STD_WINDOW_UPPER_ADDR, 16'h0056, 1'b0);
    rd(OFS_STD_WINDOW_UPPER_ADDR, 8'h00);
  endtask : t_regs

  task automatic t_window;
    wr(OFS_EXT_ADDR_AND_MODIFIER, 16'h7809, 1'b1);
    win(1'b0, 24'h001234, 32'h0);
    busAccessEnable = 1'b1;
    win(1'b0, 24'h001234, 32'h78561234);
    chk("vmeAm_q", 32'h09, vmeAm_q);
    wr(OFS_EXT_ADDR_AND_MODIFIER, 16'h7839, 1'b1);
    win(1'b0, 24'h00ABCD, 32'h7856ABCD);
    wr(OFS_EXT_ADDR_AND_MODIFIER, 16'h7829, 1'b1);
    win(1'b0, 24'h001234, 32'h78001234);
    wr(OFS_EXT_ADDR_AND_MODIFIER, 16'h000D, 1'b0);
    win(1'b1, 24'hABCDEF, 32'h78ABCDEF);
    chk("vmeAm_q", 32'h29, vmeAm_q);
    wr(OFS_EXT_ADDR_AND_MODIFIER, 16'hFFD9, 1'b1);
    win(1'b0, 24'h001234, 32'hFF001234);
    chk("vmeAm_q", 32'h19, vmeAm_q);
  endtask : t_window

  task automatic t_irq;
    irqPull = 7'h14;
    tick(8);
    chk("irqAckLevel_q", 32'h5, irqAckLevel_q);
    chk("irqAckReq_q", 32'h1, irqAckReq_q);
    wr(OFS_IRQ_LEVEL_ENABLE, 16'h006F, 1'b0);
    tick(2);
    chk("irqAckLevel_q", 32'h3, irqAckLevel_q);
    wr(OFS_SYSTEM_CONDITION_ENABLE, 16'h0099, 1'b0);
    tick(2);
    chk("irqAckReq_q", 32'h0, irqAckReq_q);
    rd(OFS_SYSTEM_CONDITION_STATUS, 8'h04);
    irqPull = 7'h00;
    tick(8);
  endtask : t_irq

  task automatic t_cond;
    wr(OFS_SYSTEM_CONDITION_ENABLE, 16'h0008, 1'b0);
    pulse(berrCycle, 1'b1);
    wr(OFS_CONDITION_CLEAR_HOLD, 16'h0021, 1'b0);
    tick(2);
    chk("cpuNmi_q", 32'h0, cpuNmi_q);
    wr(OFS_CONDITION_CLEAR_HOLD, 16'h0029, 1'b0);
    pulse(busTimeout, 1'b1);
    wr(OFS_SYSTEM_CONDITION_ENABLE, 16'h0001, 1'b0);
    tick(2);
    chk("cpuNmi_q", 32'h0, cpuNmi_q);
    rd(OFS_SYSTEM_CONDITION_STATUS, 8'h08);
    pulse(ackDone, 1'b1);
    rd(OFS_SYSTEM_CONDITION_STATUS, 8'h09);
    wr(OFS_CONDITION_CLEAR_HOLD, 16'h0000, 1'b0);
    wr(OFS_SYSTEM_CONDITION_STATUS, 16'h0000, 1'b0);
    tick(2);
    chk("cpuNmi_q", 32'h0, cpuNmi_q);
    wr(OFS_CONDITION_CLEAR_HOLD, 16'h0029, 1'b0);
    wr(OFS_SYSTEM_CONDITION_STATUS, 16'h005A, 1'b0);
    tick(2);
    chk("cpuNmi_q", 32'h1, cpuNmi_q);
    rd(OFS_SYSTEM_CONDITION_STATUS, 8'h20);
    wr(OFS_CONDITION_CLEAR_HOLD, 16'h0009, 1'b0);
    failPull = 1'b1;
    wr(OFS_SYSTEM_CONDITION_ENABLE, 16'h0080, 1'b0);
    tick(8);
    chk("cpuNmi_q", 32'h1, cpuNmi_q);
    rd(OFS_SYSTEM_CONDITION_STATUS, 8'h80);
    failPull = 1'b0;
    wr(OFS_SYSTEM_CONDITION_ENABLE, 16'h0010, 1'b0);
    acFailIn_b = 1'b0;
    tick(8);
    chk("cpuNmi_q", 32'h1, cpuNmi_q);
    rd(OFS_SYSTEM_CONDITION_STATUS, 8'h10);
    acFailIn_b = 1'b1;
  endtask : t_cond

  task automatic t_sys;
    busAccessEnable = 1'b0;
    failureLineRelease = 1'b0;
    tick(4);
    chk("sysFailOe_b_q", 32'h0, sysFailOe_b_q);
    chk("sysFailOut_q", 32'h0, sysFailOut_q);
    failureLineRelease = 1'b1;
    tick(4);
    chk("sysFailOe_b_q", 32'h1, sysFailOe_b_q);
    sysController = 1'b1;
    frontPanelReset_b = 1'b0;
    tick(8);
    chk("sysResetOe_b_q", 32'h0, sysResetOe_b_q);
    chk("sysResetOut_q", 32'h0, sysResetOut_q);
    frontPanelReset_b = 1'b1;
    sysController = 1'b0;
    tick(8);
    rstPull = 1'b1;
    tick(8);
    chk("localResetReq_q", 32'h1, localResetReq_q);
    rstPull = 1'b0;
  endtask : t_sys

  task automatic results;
    $display("compares %0d mismatches %0d", compares, failCount);
    if (failCount == 0 && compares > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask : results

  // The sequence needs under 200 cycles; the 7000-cycle limit, over thirty times that, cuts a hang short.
  initial begin
    #70us;
    failCount++;
    results();
  end

  initial begin
    {rst_b, ioWrStb, ioRdStb, ioWordAccess, winReq, winProtected, busAccessEnable} = 7'h00;
    {berrCycle, busTimeout, ackDone, sysController, failPull, rstPull} = 6'h00;
    {frontPanelReset_b, acFailIn_b, failureLineRelease} = 3'h7;
    ioAddr = 16'h0000;
    ioWrData = 16'h0000;
    cpuAddr = 24'h000000;
    irqPull = 7'h00;
    tick(6);
    rst_b = 1'b1;
    tick(8);
    t_regs();
    t_window();
    t_irq();
    t_cond();
    t_sys();
    results();
  end
endmodule : vwc_window_ctrl_tb
